// file: hdl/pcc_defines.svh
// Purpose: named offsets, fields, reset values and counts of the power and clock mode control
// Assumes: 32-bit Avalon-MM data, byte addresses, one word per register
// Notes: definitions only
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

// register byte offsets
`define PCC_OFF_PWR_CTL     5'h00
`define PCC_OFF_FLASH_STAT  5'h04
`define PCC_OFF_IAP_CMD     5'h08
`define PCC_OFF_INT_CFG     5'h0c
`define PCC_OFF_MODE_STAT   5'h10

// power control fields
`define PCC_BIT_SLEEP       0
`define PCC_BIT_DEEP        1
// flash status field
`define PCC_BIT_DBL_IND     0
// interrupt configuration: enables in the low nibble, level-sensitive selects above
`define PCC_INT_LVL_LSB     4
// mode status: state in the low bits, latched wake source and synced low pins above
`define PCC_MODE_SRC_LSB    8
`define PCC_MODE_PIN_LSB    12
// in-application programming command that turns clock doubling on
`define PCC_IAP_DBL_ON      8'h8e

// reset values
`define PCC_RST_PWR_CTL     2'h0
`define PCC_RST_INT         4'h0

// timing counts, in oscillator (ref_clk) cycles, and the number of external interrupt pins
`define PCC_WAKE_LOW_CYC    1024
`define PCC_MCYC_STD        12
`define PCC_MCYC_DBL        6
`define PCC_N_EXT           2

`endif

// file: hdl/pcc_pkg.sv
// Purpose: types shared by the power and clock mode control
// Assumes: nothing
// Notes: state codes written out
`default_nettype none
package pcc_pkg;
    typedef enum logic [2:0] {
        PCC_ST_RUN    = 3'h0,
        PCC_ST_IDLE   = 3'h1,
        PCC_ST_DOWN   = 3'h2,
        PCC_ST_OSC    = 3'h3,
        PCC_ST_RESUME = 3'h4
    } pcc_state_t;
endpackage : pcc_pkg
`default_nettype wire

// file: hdl/pcc_mcyc_if.sv
// Purpose: carries machine-cycle divider control and its tick
// Assumes: single ref_clk domain
// Notes: ctl side owns run and rate, div side owns the tick
`default_nettype none
interface pcc_mcyc_if;
    logic run;
    logic dbl;
    logic tick;
    modport ctl (output run, output dbl, input tick);
    modport div (input run, input dbl, output tick);
endinterface : pcc_mcyc_if
`default_nettype wire

// file: hdl/pcc_mcyc_div.sv
// Purpose: machine-cycle enable pulse, one every MCYC_STD or MCYC_DBL oscillator clocks
// Assumes: run and dbl come from flops on ref_clk
// Notes: a rate change mid-cycle wraps at once rather than overrunning the shorter period
`include "pcc_defines.svh"
`default_nettype none
module pcc_mcyc_div
    import pcc_pkg::*;
#(
    parameter int unsigned MCYC_STD = `PCC_MCYC_STD,
    parameter int unsigned MCYC_DBL = `PCC_MCYC_DBL
) (
    // clock and reset
    input  wire logic  ref_clk,
    input  wire logic  rst,
    // control and tick
    pcc_mcyc_if.div    mif
);
    localparam int unsigned CW = $clog2(MCYC_STD);

    generate
        if (MCYC_DBL < 2 || MCYC_STD <= MCYC_DBL) begin : g_bad
            $error("pcc_mcyc_div: unusable machine cycle lengths");
        end
    endgenerate

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] last;
    logic          tick_q;

    assign last = mif.dbl ? CW'(MCYC_DBL - 1) : CW'(MCYC_STD - 1);
    assign mif.tick = tick_q;

    // clock stopped means no machine cycles and a fresh count on restart
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (!mif.run) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q >= last) begin
            cnt_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + CW'(1);
            tick_q <= 1'b0;
        end
    end
endmodule // pcc_mcyc_div
`default_nettype wire

// file: hdl/pcc_power_clock_ctl.sv
// Purpose: sleep and deep-sleep control plus 12/6 clock machine-cycle rate selection
// Assumes: ref_clk 200 MHz is the oscillator clock; core pulses irq_start as an interrupt begins
// Notes: Avalon-MM slave, one wait cycle per access; unmapped reads return zero
//
// Behaviour
// R01: setting sleep bit enters sleep state
// R02: sleep halts program counter, clock keeps running
// R03: sleep never disturbs RAM or registers
// R04: interrupt start in sleep clears bit, exits
// R05: execution resumes after the requesting instruction
// R06: hardware reset ends low power, full restart
// R07: setting deep-sleep bit enters deep sleep
// R08: deep sleep stops clock; only level interrupts
// R09: deep sleep keeps SRAM contents
// R10: only enabled level interrupt or reset wakes
// R11: low input restarts oscillator, 1024 cycles minimum
// R12: release high starts interrupt service routine
// R13: default twelve clocks per machine cycle
// R14: doubling gives six clocks per machine cycle
// R15: doubling enabled by host or IN_APPLICATION_PROGRAMMING command
// R16: flash status bit shows six-clock mode
// R17: doubling only internal clock with access select high
// R18: external clock drives input pin, output open
// R19: both request bits together mean deep sleep
`include "pcc_defines.svh"
`default_nettype none
module pcc_power_clock_ctl
    import pcc_pkg::*;
#(
    parameter int unsigned WAKE_LOW_CYC = `PCC_WAKE_LOW_CYC,
    parameter int unsigned MCYC_STD     = `PCC_MCYC_STD,
    parameter int unsigned MCYC_DBL     = `PCC_MCYC_DBL,
    parameter int unsigned N_EXT        = `PCC_N_EXT
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // avalon-mm slave
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output var  logic [31:0]       avs_readdata,
    output var  logic              avs_waitrequest,
    // pins
    input  wire logic [N_EXT-1:0]  ext_int_n,
    input  wire logic              external_access_select,
    input  wire logic              host_dbl_req,
    // core side
    input  wire logic              irq_start,
    output var  logic              core_run,
    output var  logic              sys_clk_run,
    output var  logic              osc_run,
    output var  logic              wake_req,
    output var  logic              double_clock_indicator,
    output logic                   mcyc_tick
);
    localparam int unsigned LCW = $clog2(WAKE_LOW_CYC + 1);

    generate
        if (N_EXT < 1 || N_EXT > 4 || WAKE_LOW_CYC < 2) begin : g_bad
            $error("pcc_power_clock_ctl: unsupported parameters");
        end
    endgenerate

    function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] off);
        return addr == off;
    endfunction

    pcc_state_t         state_q;
    logic [N_EXT-1:0]   ext_s1_q, ext_n_s2_q;
    logic               ea_s1_q, ea_s2_q, host_s1_q, host_s2_q;
    logic               sleep_q, deep_q, dbl_q;
    logic [N_EXT-1:0]   int_en_q, int_lvl_q, wake_src_q;
    logic [LCW-1:0]     low_cnt_q;
    logic [31:0]        rd_mux;
    logic               wr_ok, pwr_wr, src_low;
    logic [N_EXT-1:0]   wake_pins;

    pcc_mcyc_if mif ();

    // pins come from outside ref_clk domain
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ext_s1_q   <= '1;
            ext_n_s2_q <= '1;
            ea_s1_q    <= 1'b0;
            ea_s2_q    <= 1'b0;
            host_s1_q  <= 1'b0;
            host_s2_q  <= 1'b0;
        end else begin
            ext_s1_q   <= ext_int_n;
            ext_n_s2_q <= ext_s1_q;
            ea_s1_q    <= external_access_select;
            ea_s2_q    <= ea_s1_q;
            host_s1_q  <= host_dbl_req;
            host_s2_q  <= host_s1_q;
        end
    end

    // bus: request seen with waitrequest high, answered the next cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0;
        end
    end

    assign wr_ok  = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign pwr_wr = wr_ok && reg_hit(avs_address, `PCC_OFF_PWR_CTL);

    always_comb begin
        rd_mux = '0;
        if (reg_hit(avs_address, `PCC_OFF_PWR_CTL)) begin
            rd_mux[`PCC_BIT_SLEEP] = sleep_q;
            rd_mux[`PCC_BIT_DEEP]  = deep_q;
        end else if (reg_hit(avs_address, `PCC_OFF_FLASH_STAT)) begin
            rd_mux[`PCC_BIT_DBL_IND] = dbl_q; // R16
        end else if (reg_hit(avs_address, `PCC_OFF_INT_CFG)) begin
            rd_mux[N_EXT-1:0] = int_en_q;
            rd_mux[`PCC_INT_LVL_LSB +: N_EXT] = int_lvl_q;
        end else if (reg_hit(avs_address, `PCC_OFF_MODE_STAT)) begin
            rd_mux[2:0] = state_q;
            rd_mux[`PCC_MODE_SRC_LSB +: N_EXT] = wake_src_q;
            rd_mux[`PCC_MODE_PIN_LSB +: N_EXT] = ~ext_n_s2_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
        end
    end

    // request bits; a write in the same cycle as interrupt start wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {deep_q, sleep_q} <= `PCC_RST_PWR_CTL; // R06
        end else if (pwr_wr) begin
            sleep_q <= avs_writedata[`PCC_BIT_SLEEP]; // R01
            deep_q  <= avs_writedata[`PCC_BIT_DEEP]; // R07
        end else if (irq_start && (state_q == PCC_ST_IDLE || state_q == PCC_ST_RESUME)) begin
            sleep_q <= 1'b0; // R04
            deep_q  <= 1'b0; // R10
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            int_en_q  <= N_EXT'(`PCC_RST_INT);
            int_lvl_q <= N_EXT'(`PCC_RST_INT);
        end else if (wr_ok && reg_hit(avs_address, `PCC_OFF_INT_CFG)) begin
            int_en_q  <= avs_writedata[N_EXT-1:0];
            int_lvl_q <= avs_writedata[`PCC_INT_LVL_LSB +: N_EXT];
        end
    end

    // edge-configured or disabled inputs never wake from deep sleep
    assign wake_pins = int_en_q & int_lvl_q & ~ext_n_s2_q; // R08 R10
    assign src_low   = |(wake_src_q & ~ext_n_s2_q);

    // ram and registers are never touched by mode changes, only by reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= PCC_ST_RUN; // R06
        end else begin
            case (state_q)
                PCC_ST_RUN: begin
                    if (deep_q) begin
                        state_q <= PCC_ST_DOWN; // R07 R19
                    end else if (sleep_q) begin
                        state_q <= PCC_ST_IDLE; // R01
                    end
                end
                PCC_ST_IDLE: begin
                    if (irq_start) begin
                        state_q <= PCC_ST_RUN; // R04 R03
                    end
                end
                PCC_ST_DOWN: begin
                    if (|wake_pins) begin
                        state_q <= PCC_ST_OSC; // R11 R09
                    end
                end
                PCC_ST_OSC: begin
                    if (!src_low) begin
                        // released too early: oscillator goes back to sleep
                        state_q <= (low_cnt_q >= LCW'(WAKE_LOW_CYC)) ? PCC_ST_RESUME : PCC_ST_DOWN; // R11 R12
                    end
                end
                PCC_ST_RESUME: begin
                    if (irq_start) begin
                        state_q <= PCC_ST_RUN; // R10
                    end
                end
                default: begin
                    state_q <= PCC_ST_RUN;
                end
            endcase
        end
    end

    // low time counted in oscillator cycles, saturating
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_cnt_q  <= '0;
            wake_src_q <= '0;
        end else if (state_q == PCC_ST_DOWN) begin
            low_cnt_q  <= LCW'(1);
            wake_src_q <= wake_pins;
        end else if (state_q == PCC_ST_OSC && src_low && low_cnt_q < LCW'(WAKE_LOW_CYC)) begin
            low_cnt_q <= low_cnt_q + LCW'(1); // R11
        end
    end

    // outputs follow the state one cycle later
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core_run    <= 1'b0;
            sys_clk_run <= 1'b0;
            osc_run     <= 1'b0;
            wake_req    <= 1'b0;
        end else begin
            core_run    <= state_q == PCC_ST_RUN || state_q == PCC_ST_RESUME; // R02 R05 R12
            sys_clk_run <= state_q != PCC_ST_DOWN && state_q != PCC_ST_OSC; // R02 R08
            osc_run     <= state_q != PCC_ST_DOWN; // R08 R11
            wake_req    <= state_q == PCC_ST_RESUME; // R12
        end
    end

    // doubling is sticky until hardware reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dbl_q <= 1'b0; // R13
        end else if (host_s2_q || (wr_ok && reg_hit(avs_address, `PCC_OFF_IAP_CMD)
                                   && avs_writedata[7:0] == `PCC_IAP_DBL_ON)) begin
            dbl_q <= 1'b1; // R15
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            double_clock_indicator <= 1'b0;
        end else begin
            double_clock_indicator <= dbl_q; // R16
        end
    end

    // the oscillator output pin is not in this path, so it is never doubled
    assign mif.dbl   = dbl_q && ea_s2_q; // R14 R17
    assign mif.run   = sys_clk_run;
    assign mcyc_tick = mif.tick;

    pcc_mcyc_div #(
        .MCYC_STD (MCYC_STD),
        .MCYC_DBL (MCYC_DBL)
    ) u_div (
        .ref_clk (ref_clk),
        .rst     (rst),
        .mif     (mif.div)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    enter_idle_a : assert property ( // R01
        state_q == PCC_ST_RUN && sleep_q && !deep_q |=> state_q == PCC_ST_IDLE ##1 !core_run && sys_clk_run)
        else $error("sleep request did not halt core");
    idle_clock_a : assert property ( // R02
        state_q == PCC_ST_IDLE ##1 state_q == PCC_ST_IDLE |-> !core_run && sys_clk_run && osc_run)
        else $error("clock or core wrong in sleep");
    idle_exit_a : assert property ( // R04
        state_q == PCC_ST_IDLE && irq_start && !pwr_wr |=> state_q == PCC_ST_RUN && !sleep_q ##1 core_run)
        else $error("interrupt did not end sleep");
    deep_enter_a : assert property ( // R19
        state_q == PCC_ST_RUN && deep_q |=> state_q == PCC_ST_DOWN ##1 !osc_run && !sys_clk_run)
        else $error("deep sleep not entered");
    edge_ignored_a : assert property ( // R10
        state_q == PCC_ST_DOWN && wake_pins == '0 |=> state_q == PCC_ST_DOWN)
        else $error("deep sleep left without level interrupt");
    low_min_a : assert property ( // R11
        $rose(state_q == PCC_ST_RESUME) |-> $past(low_cnt_q) >= LCW'(WAKE_LOW_CYC) && !src_low)
        else $error("wake before minimum low time");
    resume_run_a : assert property ( // R12
        $rose(state_q == PCC_ST_RESUME) |=> core_run && wake_req && sys_clk_run)
        else $error("service routine not started on release");
    host_dbl_a : assert property ( // R15
        host_s2_q |=> dbl_q ##1 double_clock_indicator)
        else $error("host request did not enable doubling");
    ext_access_a : assert property ( // R17
        !ea_s2_q |-> !mif.dbl)
        else $error("doubling with external access");
    bus_answer_a : assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle later");

    idle_trip_c  : cover property (state_q == PCC_ST_IDLE ##[1:20] state_q == PCC_ST_RUN);
    deep_wake_c  : cover property (state_q == PCC_ST_RESUME ##[1:20] state_q == PCC_ST_RUN);
    early_rel_c  : cover property (state_q == PCC_ST_OSC ##1 state_q == PCC_ST_DOWN);
    dbl_run_c    : cover property (mif.dbl && mcyc_tick);
endmodule // pcc_power_clock_ctl
`default_nettype wire

// file: tb/pcc_core_model.sv
// Purpose: processor core stand-in that answers pending interrupts with an irq_start pulse
// Assumes: single ref_clk domain, same clock as the control block
// Notes: lat sets how many cycles the core waits before taking the interrupt
`default_nettype none
module pcc_core_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // wake request from the control block, interrupt pending from the bench
    input  wire logic       wake_req,
    input  wire logic       irq_pend,
    input  wire logic [3:0] lat,
    // interrupt start to the control block
    output var  logic       irq_start
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] ph_q;
    logic [3:0] cnt_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ph_q      <= 2'h0;
            cnt_q     <= 4'h0;
            irq_start <= 1'b0;
        end else begin
            irq_start <= 1'b0;
            case (ph_q)
                2'h0: begin
                    if (wake_req || irq_pend) begin
                        ph_q  <= 2'h1;
                        cnt_q <= lat;
                    end
                end
                2'h1: begin
                    if (cnt_q == 4'h0) begin
                        irq_start <= 1'b1;
                        ph_q      <= 2'h2;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                // hold off until the request is gone, so one interrupt gives one pulse
                default: begin
                    if (!wake_req && !irq_pend) begin
                        ph_q <= 2'h0;
                    end
                end
            endcase
        end
    end
endmodule // pcc_core_model
`default_nettype wire

// file: tb/test_power_and_clock_mode_control.sv
// Purpose: self-checking bench for the power and clock mode control
// Assumes: wake hold count shortened to 8 cycles
// Notes: random config, hold lengths and core latency from a fixed seed
`include "pcc_defines.svh"
`default_nettype none
module test_power_and_clock_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WLC = 8;

    logic        ref_clk, rst, avs_read, avs_write, ea, host_dbl, irq_start, irq_pend;
    logic        core_run, sys_clk_run, osc_run, wake_req, dbl_ind, mcyc_tick, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable, lat;
    logic [1:0]  ext_int_n;
    int          fail_count, num_checks, p, hold;

    pcc_power_clock_ctl #(.WAKE_LOW_CYC(WLC)) pcc_power_clock_ctl_i (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_int_n(ext_int_n),
        .external_access_select(ea), .host_dbl_req(host_dbl), .irq_start(irq_start),
        .core_run(core_run), .sys_clk_run(sys_clk_run), .osc_run(osc_run), .wake_req(wake_req),
        .double_clock_indicator(dbl_ind), .mcyc_tick(mcyc_tick));

    pcc_core_model pcc_core_model_i (.ref_clk(ref_clk), .rst(rst), .wake_req(wake_req),
        .irq_pend(irq_pend), .lat(lat), .irq_start(irq_start));

    // external clock source drives the oscillator input directly
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    function automatic int exp_period(input bit dbl, input bit sel);
        return (dbl && sel) ? `PCC_MCYC_DBL : `PCC_MCYC_STD;
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) chk("bus answer", 32'h0, 32'h1);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // tick-to-tick distance; the first wait only lines up on a tick
    task automatic period(output int q);
        int n;
        n = 0;
        cyc(1);
        while (mcyc_tick !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        q = 0;
        do begin
            cyc(1);
            q++;
        end while (mcyc_tick !== 1'b1 && q < 100);
    endtask

    task automatic wait_run();
        int n;
        n = 0;
        while (core_run !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        cyc(16);
        chk("core_run in reset", {31'h0, core_run}, 32'h0);
        rst <= 1'b0;
        cyc(3);
    endtask

    initial begin
        logic [31:0] cfg;
        rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 5'h00;
        avs_writedata = 32'h0; avs_byteenable = 4'hf; ext_int_n = 2'h3; ea = 1'b1;
        host_dbl = 1'b0; irq_pend = 1'b0; lat = 4'h0; fail_count = 0; num_checks = 0;
        void'($urandom(83));
        do_reset();
        bus(1'b0, `PCC_OFF_PWR_CTL, 32'h0, rd);
        chk("pwr_ctl reset", rd, 32'h0);
        bus(1'b0, `PCC_OFF_FLASH_STAT, 32'h0, rd);
        chk("flash_stat reset", rd, 32'h0);
        bus(1'b0, 5'h14, 32'h0, rd);
        chk("unmapped read", rd, 32'h0);
        period(p);
        chk("period std", p, exp_period(0, 1));
        $display("test reset_default done");

        cfg = $urandom & 32'h33;
        bus(1'b1, `PCC_OFF_INT_CFG, cfg, rd);
        avs_byteenable <= 4'h0;
        bus(1'b1, `PCC_OFF_PWR_CTL, 32'h1, rd);
        avs_byteenable <= 4'hf;
        cyc(3);
        chk("masked write", {31'h0, core_run}, 32'h1);
        bus(1'b1, `PCC_OFF_PWR_CTL, 32'h1, rd);
        cyc(3);
        chk("sleep core_run", {31'h0, core_run}, 32'h0);
        chk("sleep clk", {31'h0, sys_clk_run}, 32'h1);
        period(p);
        chk("sleep period", p, exp_period(0, 1));
        bus(1'b0, `PCC_OFF_MODE_STAT, 32'h0, rd);
        chk("sleep state", rd & 32'h7, 32'h1);
        bus(1'b0, `PCC_OFF_INT_CFG, 32'h0, rd);
        chk("cfg kept", rd, cfg);
        lat <= 4'($urandom_range(0, 9));
        irq_pend <= 1'b1;
        wait_run();
        irq_pend <= 1'b0;
        chk("sleep wake", {31'h0, core_run}, 32'h1);
        bus(1'b0, `PCC_OFF_PWR_CTL, 32'h0, rd);
        chk("sleep bit cleared", rd, 32'h0);
        $display("test sleep done");

        bus(1'b1, `PCC_OFF_INT_CFG, 32'h11, rd);
        bus(1'b1, `PCC_OFF_PWR_CTL, 32'h2, rd);
        cyc(3);
        chk("deep osc", {30'h0, osc_run, sys_clk_run}, 32'h0);
        ext_int_n <= 2'h1;
        cyc(20);
        chk("disabled pin", {31'h0, osc_run}, 32'h0);
        bus(1'b1, `PCC_OFF_INT_CFG, 32'h13, rd);
        cyc(20);
        chk("edge pin", {31'h0, osc_run}, 32'h0);
        ext_int_n <= 2'h2;
        cyc(4);
        ext_int_n <= 2'h3;
        cyc(12);
        chk("short low", {30'h0, osc_run, core_run}, 32'h0);
        hold = WLC + 4 + $urandom_range(0, 20);
        ext_int_n <= 2'h2;
        cyc(hold);
        chk("osc restart", {31'h0, osc_run}, 32'h1);
        chk("no run while low", {31'h0, core_run}, 32'h0);
        bus(1'b0, `PCC_OFF_MODE_STAT, 32'h0, rd);
        chk("osc state", rd & 32'h3307, 32'h1103);
        ext_int_n <= 2'h3;
        lat <= 4'($urandom_range(0, 9));
        wait_run();
        chk("deep wake", {31'h0, core_run}, 32'h1);
        chk("wake pending", {31'h0, wake_req}, 32'h1);
        cyc(14);
        chk("wake taken", {31'h0, wake_req}, 32'h0);
        bus(1'b0, `PCC_OFF_PWR_CTL, 32'h0, rd);
        chk("deep bit cleared", rd, 32'h0);
        $display("test deep_sleep done");

        bus(1'b1, `PCC_OFF_PWR_CTL, 32'h3, rd);
        cyc(3);
        chk("both bits", {31'h0, osc_run}, 32'h0);
        bus(1'b0, `PCC_OFF_MODE_STAT, 32'h0, rd);
        chk("both state", rd & 32'h7, 32'h2);
        do_reset();
        chk("reset exit", {29'h0, core_run, sys_clk_run, osc_run}, 32'h7);
        bus(1'b0, `PCC_OFF_PWR_CTL, 32'h0, rd);
        chk("reset bits", rd, 32'h0);
        $display("test reset_in_deep done");

        bus(1'b1, `PCC_OFF_IAP_CMD, 32'h8e, rd);
        cyc(4);
        chk("iap dbl", {31'h0, dbl_ind}, 32'h1);
        bus(1'b0, `PCC_OFF_FLASH_STAT, 32'h0, rd);
        chk("flash_stat dbl", rd, 32'h1);
        period(p);
        period(p);
        chk("period dbl", p, exp_period(1, 1));
        ea <= 1'b0;
        period(p);
        period(p);
        chk("period ea low", p, exp_period(1, 0));
        host_dbl <= 1'b1;
        ea <= 1'b1;
        do_reset();
        cyc(4);
        chk("host dbl", {31'h0, dbl_ind}, 32'h1);
        period(p);
        period(p);
        chk("host period", p, exp_period(1, 1));
        $display("test doubling done");
        final_report();
    end

    initial begin
        repeat (50000) @(posedge ref_clk);
        fail_count++;
        final_report();
    end
endmodule // test_power_and_clock_mode_control
`default_nettype wire
